// ==== src/usbep_defines.vh ====
`ifndef USBEP_DEFINES_VH
`define USBEP_DEFINES_VH
// ==========================================
// Register indices (byte address = 4 * index)
`define USBEP_IX_FNUML 8'hba
`define USBEP_IX_GIF 8'hbd
`define USBEP_IX_GIE 8'hbe
`define USBEP_IX_EIE 8'hc2
`define USBEP_IX_ADDR 8'hc6
`define USBEP_IX_SEL 8'hc7
`define USBEP_IX_STA 8'hce
`define USBEP_IX_DAT 8'hcf
`define USBEP_IX_CON 8'hd4
`define USBEP_IX_FRST 8'hd5
`define USBEP_IX_CNT 8'he2
`define USBEP_IX_EIF 8'hf8
// ==========================================
// Reset values, SETUP status value and flag mask
`define USBEP_GIE_RST 8'h10
`define USBEP_CON_RST 8'h80
`define USBEP_ZERO_RST 8'h00
`define USBEP_STA_SU_VAL 8'h04
`define USBEP_GIF_MASK 8'h39
// ==========================================
// Field positions
`define USBEP_GIF_WAKE 5
`define USBEP_GIF_REND 4
`define USBEP_GIF_SOF 3
`define USBEP_GIF_IDLE 0
`define USBEP_ADDR_FON 7
`define USBEP_CON_ON 7
`define USBEP_CON_NAKIE 6
`define USBEP_CON_NAKO 5
`define USBEP_CON_NAKI 4
`define USBEP_CON_TGL 3
`define USBEP_CON_DIR 2
`define USBEP_STA_CDIR 7
`define USBEP_STA_B1 6
`define USBEP_STA_STLRQ 5
`define USBEP_STA_IN_PACKET_READY 4
`define USBEP_STA_STL 3
`define USBEP_STA_SU 2
`define USBEP_STA_B0 1
`define USBEP_STA_IN_COMPLETE_FLAG 0
// ==========================================
// Encodings
`define USBEP_KIND_CTRL 2'h0
`define USBEP_KIND_ISO 2'h1
`define USBEP_TOK_OUT 2'h0
`define USBEP_TOK_IN 2'h1
`define USBEP_TOK_SETUP 2'h2
`define USBEP_HS_NONE 2'h0
`define USBEP_HS_GO 2'h1
`define USBEP_HS_NAK 2'h2
`define USBEP_HS_STALL 2'h3
// ==========================================
// Timing
`define USBEP_CLK_PS 100000
`define USBEP_CLK_NS 100
`define USBEP_BIT_PS 83333
`define USBEP_RST_BITS 32
`define USBEP_RST_CYC ((`USBEP_RST_BITS * `USBEP_BIT_PS + `USBEP_CLK_PS - 1) / `USBEP_CLK_PS)
`define USBEP_IDLE_US 3000
`define USBEP_IDLE_CYC ((`USBEP_IDLE_US * 1000) / `USBEP_CLK_NS)
`endif

// ==== src/usbep_sync.v ====
`timescale 1ns/1ns
// ==========================================
// Two-stage synchroniser for line pins
module usbep_sync
(
  input wire clk,
  input wire rst,
  input wire [1:0] d,
  output wire [1:0] q
);
  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1)
    begin : g_bit
      reg s1_r;
      reg s2_r;
      // First stage feeds only the second
      always @(posedge clk)
      begin
        if (rst)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end
        else
        begin
          s1_r <= d[b];
          s2_r <= s1_r;
        end
      end
      assign q[b] = s2_r;
    end
  endgenerate
endmodule

// ==== src/usbep_ram.v ====
`timescale 1ns/1ns
// ==========================================
// Endpoint FIFO storage, registered read
module usbep_ram
(
  input wire clk,
  input wire rst,
  input wire we,
  input wire [7:0] waddr,
  input wire [7:0] wdata,
  input wire re,
  input wire [7:0] raddr,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:255];
  // Storage itself has no reset
  always @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end
  // Read data held until next read
  always @(posedge clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (re)
      rdata <= mem[raddr];
  end
endmodule

// ==== src/usbep_top.v ====
// Overview of operation
// (RL1) Function enable cleared at power-up, sticky
// (RL2) Address field zero after reset
// (RL3) Wake flag on host signalling while suspended
// (RL4) End-of-reset flag sticky until cleared
// (RL5) Frame-start flag on each good SOF
// (RL6) Suspend flag after 3 ms idle
// (RL7) Flags interrupt only when enabled
// (RL8) Selector picks endpoint behind shared registers
// (RL9) Endpoint control resets enabled
// (RL10) NAK-sent flags for OUT and IN
// (RL11) Direction bit ignored on control endpoints
// (RL12) Firmware drives control-direction bit
// (RL13) Bank full flags, NAK further OUT
// (RL14) SETUP may overwrite FIFO anytime
// (RL15) Stall request answers next handshake
// (RL16) Transmit-ready cleared when IN completes
// (RL17) Stall-sent or CRC error flag
// (RL18) SETUP sets flag, clears other status
// (RL19) IN-complete flag after send or ACK
// (RL20) Firmware pulses FIFO reset bit
// (RL21) Per-endpoint flag when enabled
// (RL22) Byte count of last received packet
// (RL23) Bus reset is SE0 for 32 bits
// (RL24) FIFO data register streams bytes
// (RL25) One interrupt ORs all enabled flags
`timescale 1ns/1ns
`include "usbep_defines.vh"
module usbep_top
#(
  parameter [14:0] IDLE_CYC = `USBEP_IDLE_CYC
)
(
  input wire MCLK,
  input wire RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  input wire LINE_SE0,
  input wire LINE_J,
  input wire PKT_TOKEN,
  input wire [1:0] PKT_KIND,
  input wire [1:0] PKT_EP,
  input wire PKT_DONE,
  input wire PKT_PID1,
  input wire PKT_CRC_ERR,
  input wire PKT_ACKED,
  input wire PKT_SOF,
  input wire [7:0] SOF_FRAME,
  input wire RX_VALID,
  input wire [7:0] RX_BYTE,
  input wire TX_READ,
  output wire [7:0] TX_BYTE,
  output wire TX_AVAIL,
  output wire HS_VALID,
  output wire [1:0] HS_CODE,
  output wire [6:0] FUNC_ADDR,
  output wire FUNC_ON,
  output wire IRQ
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_WR = 4'b0010;
  localparam [3:0] S_RD1 = 4'b0100;
  localparam [3:0] S_RD2 = 4'b1000;
  localparam [14:0] IDLE_LAST = IDLE_CYC - 15'd1;
  localparam integer RST_CYC_I = `USBEP_RST_CYC;
  localparam [4:0] RST_CYC = RST_CYC_I[4:0];
  localparam [4:0] RST_LAST = RST_CYC - 5'd1;

  reg [3:0] st_r;
  reg [3:0] st_nxt;
  reg [7:0] ix_r;
  reg [31:0] hrdata_r;
  reg fifo_rd_r;
  reg [7:0] rd_mux;
  reg [7:0] gif_r;
  reg [7:0] gie_r;
  reg [2:0] eie_r;
  reg [2:0] eif_r;
  reg [7:0] addr_r;
  reg [1:0] sel_r;
  reg [2:0] fclr_r;
  reg [7:0] frm_r;
  reg [6:0] rxcnt_r;
  reg hs_valid_r;
  reg [1:0] hs_code_r;
  reg irq_r;
  reg susp_r;
  reg [14:0] idle_cnt_r;
  reg [4:0] se0_cnt_r;
  reg se0_long_r;
  wire [1:0] line_s;
  wire se0_s;
  wire j_s;
  wire [31:0] con_all;
  wire [31:0] sta_all;
  wire [27:0] cnt_all;
  wire [23:0] wp_all;
  wire [23:0] rp_all;
  wire [7:0] hs_all;
  wire [2:0] evt;
  wire [7:0] ram_q;

  // ==========================================
  // Bus slave
  wire accept = HSEL & HTRANS[1] & HREADY;
  wire dat_ix = (ix_r == `USBEP_IX_DAT);
  wire wr_block = dat_ix & RX_VALID;
  wire rd_block = dat_ix & TX_READ;
  wire wr_fire = st_r[1] & ~wr_block;
  wire rd_fire = st_r[2] & ~rd_block;
  wire [7:0] wd = HWDATA[7:0];
  assign HREADYOUT = st_r[0] | (st_r[1] & ~wr_block) | st_r[3];
  assign HRESP = 1'b0;
  assign HRDATA = fifo_rd_r ? {24'h000000, ram_q} : hrdata_r;

  // Next bus state; link FIFO traffic takes priority over the bus
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE, S_WR, S_RD2:
        if (HREADYOUT)
          st_nxt = accept ? (HWRITE ? S_WR : S_RD1) : S_IDLE;
      S_RD1:
        if (~rd_block)
          st_nxt = S_RD2;
      default:
        st_nxt = S_IDLE;
    endcase
  end

  always @(posedge MCLK)
  begin
    if (RST)
    begin
      st_r <= S_IDLE;
      ix_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      fifo_rd_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (HREADYOUT & accept)
        ix_r <= HADDR[9:2];
      if (rd_fire)
      begin
        hrdata_r <= {24'h000000, rd_mux};
        fifo_rd_r <= dat_ix;
      end
    end
  end

  // Register read multiplexer; indirect ones follow the selector
  always @*
  begin
    case (ix_r)
      `USBEP_IX_FNUML: rd_mux = frm_r;
      `USBEP_IX_GIF: rd_mux = gif_r;
      `USBEP_IX_GIE: rd_mux = gie_r;
      `USBEP_IX_EIE: rd_mux = {5'h00, eie_r};
      `USBEP_IX_ADDR: rd_mux = addr_r;
      `USBEP_IX_SEL: rd_mux = {6'h00, sel_r};
      `USBEP_IX_STA: rd_mux = sta_all[8*sel_r +: 8]; // [RL8]
      `USBEP_IX_CON: rd_mux = con_all[8*sel_r +: 8]; // [RL8]
      `USBEP_IX_FRST: rd_mux = {5'h00, fclr_r};
      `USBEP_IX_CNT: rd_mux = {1'b0, cnt_all[7*sel_r +: 7]}; // [RL22]
      `USBEP_IX_EIF: rd_mux = {5'h00, eif_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // ==========================================
  // Line state
  usbep_sync u_sync
  (
    .clk(MCLK),
    .rst(RST),
    .d({LINE_J, LINE_SE0}),
    .q(line_s)
  );
  assign se0_s = line_s[0];
  assign j_s = line_s[1];
  wire bus_rst = se0_s & (se0_cnt_r == RST_LAST); // [RL23]
  wire rst_end = ~se0_s & se0_long_r;
  wire idle_hit = j_s & (idle_cnt_r == IDLE_LAST);
  wire wake_hit = susp_r & ~j_s;
  wire wr_gif = wr_fire & (ix_r == `USBEP_IX_GIF);

  // Idle and SE0 duration counters, both saturating
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      idle_cnt_r <= 15'h0000;
      se0_cnt_r <= 5'h00;
      se0_long_r <= 1'b0;
      susp_r <= 1'b0;
    end
    else
    begin
      if (~j_s)
        idle_cnt_r <= 15'h0000;
      else if (idle_cnt_r != IDLE_CYC)
        idle_cnt_r <= idle_cnt_r + 15'd1;
      if (~se0_s)
        se0_cnt_r <= 5'h00;
      else if (se0_cnt_r != RST_CYC)
        se0_cnt_r <= se0_cnt_r + 5'd1;
      if (bus_rst)
        se0_long_r <= 1'b1;
      else if (rst_end)
        se0_long_r <= 1'b0;
      // Suspended until host wakes us or software clears the flag
      if (idle_hit)
        susp_r <= 1'b1;
      else if (wake_hit | (wr_gif & ~wd[`USBEP_GIF_IDLE]))
        susp_r <= 1'b0;
    end
  end

  // ==========================================
  // Global registers
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      gif_r <= `USBEP_ZERO_RST;
      gie_r <= `USBEP_GIE_RST; // [RL7]
      eie_r <= 3'h0;
      eif_r <= 3'h0;
      addr_r <= `USBEP_ZERO_RST; // [RL1] [RL2]
      sel_r <= 2'h0;
      fclr_r <= 3'h0;
      frm_r <= `USBEP_ZERO_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      // Flags clear on written zero; a hardware set below wins
      if (wr_gif)
        gif_r <= gif_r & wd & `USBEP_GIF_MASK;
      if (wake_hit)
        gif_r[`USBEP_GIF_WAKE] <= 1'b1; // [RL3]
      if (rst_end)
        gif_r[`USBEP_GIF_REND] <= 1'b1; // [RL4]
      if (PKT_SOF)
        gif_r[`USBEP_GIF_SOF] <= 1'b1; // [RL5]
      if (idle_hit)
        gif_r[`USBEP_GIF_IDLE] <= 1'b1; // [RL6]
      if (PKT_SOF)
        frm_r <= SOF_FRAME;
      if (wr_fire & (ix_r == `USBEP_IX_GIE))
        gie_r <= wd & `USBEP_GIF_MASK;
      if (wr_fire & (ix_r == `USBEP_IX_EIE))
        eie_r <= wd[2:0];
      if (wr_fire & (ix_r == `USBEP_IX_EIF))
        eif_r <= (eif_r & wd[2:0]) | (evt & eie_r);
      else
        eif_r <= eif_r | (evt & eie_r); // [RL21]
      // Enable bit is sticky: firmware can set but never clear it
      if (wr_fire & (ix_r == `USBEP_IX_ADDR))
        addr_r <= {addr_r[`USBEP_ADDR_FON] | wd[`USBEP_ADDR_FON], wd[6:0]}; // [RL1]
      if (bus_rst)
        addr_r[6:0] <= 7'h00; // [RL2] [RL23]
      if (wr_fire & (ix_r == `USBEP_IX_SEL))
        sel_r <= wd[1:0]; // [RL8]
      if (wr_fire & (ix_r == `USBEP_IX_FRST))
        fclr_r <= wd[2:0]; // [RL20]
      irq_r <= (|(gif_r & gie_r)) | (|(eif_r & eie_r)); // [RL7] [RL25]
    end
  end

  // ==========================================
  // Packet bookkeeping and handshake answer
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      rxcnt_r <= 7'h00;
      hs_valid_r <= 1'b0;
      hs_code_r <= `USBEP_HS_NONE;
    end
    else
    begin
      if (PKT_TOKEN)
        rxcnt_r <= 7'h00;
      else if (RX_VALID)
        rxcnt_r <= rxcnt_r + 7'd1;
      hs_valid_r <= PKT_TOKEN;
      if (PKT_TOKEN)
        hs_code_r <= hs_all[2*PKT_EP +: 2];
    end
  end
  assign HS_VALID = hs_valid_r;
  assign HS_CODE = hs_code_r;
  assign FUNC_ADDR = addr_r[6:0];
  assign FUNC_ON = addr_r[`USBEP_ADDR_FON];
  assign IRQ = irq_r;

  // ==========================================
  // Per-endpoint control, status and FIFO pointers
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_ep
      localparam [1:0] EPN = i;
      reg [7:0] con_r;
      reg [7:0] sta_r;
      reg [6:0] cnt_r;
      reg [5:0] wp_r;
      reg [5:0] rp_r;
      reg bank_r;
      reg [1:0] hs;
      wire hit = (PKT_EP == EPN);
      wire sel = (sel_r == EPN);
      wire ctrl = (con_r[1:0] == `USBEP_KIND_CTRL);
      wire iso = (con_r[1:0] == `USBEP_KIND_ISO);
      wire pp = (EPN != 2'h0);
      wire dir_in = con_r[`USBEP_CON_DIR];
      wire full = sta_r[`USBEP_STA_B0] & (~pp | sta_r[`USBEP_STA_B1]);
      wire tok = PKT_TOKEN & hit;
      wire done = PKT_DONE & hit;
      wire nako = tok & (PKT_KIND == `USBEP_TOK_OUT) & (hs == `USBEP_HS_NAK);
      wire naki = tok & (PKT_KIND == `USBEP_TOK_IN) & (hs == `USBEP_HS_NAK);
      wire stl = (tok & (hs == `USBEP_HS_STALL)) | (PKT_CRC_ERR & hit & iso);
      wire su = done & (PKT_KIND == `USBEP_TOK_SETUP);
      wire od = done & (PKT_KIND == `USBEP_TOK_OUT);
      wire ind = PKT_ACKED & hit;
      wire clr = fclr_r[i];
      wire fw = wr_fire & dat_ix & sel;
      wire fr = rd_fire & dat_ix & sel;

      // Answer to a token; direction only matters off control
      always @*
      begin
        hs = `USBEP_HS_NONE;
        if (con_r[`USBEP_CON_ON])
        begin
          case (PKT_KIND)
            `USBEP_TOK_SETUP:
              if (ctrl)
                hs = `USBEP_HS_GO;
            `USBEP_TOK_OUT:
              if (ctrl | ~dir_in) // [RL11]
              begin
                if (sta_r[`USBEP_STA_STLRQ] & ~iso)
                  hs = `USBEP_HS_STALL; // [RL15]
                else if (full & ~iso)
                  hs = `USBEP_HS_NAK; // [RL13]
                else
                  hs = `USBEP_HS_GO;
              end
            `USBEP_TOK_IN:
              if (ctrl | dir_in) // [RL11]
              begin
                if (sta_r[`USBEP_STA_STLRQ] & ~iso)
                  hs = `USBEP_HS_STALL; // [RL15]
                else if (sta_r[`USBEP_STA_IN_PACKET_READY])
                  hs = `USBEP_HS_GO; // [RL16]
                else
                  hs = `USBEP_HS_NAK;
              end
            default:
              hs = `USBEP_HS_NONE;
          endcase
        end
      end

      assign evt[i] = su | od | stl | ind | (con_r[`USBEP_CON_NAKIE] & (nako | naki)); // [RL21]

      always @(posedge MCLK)
      begin
        if (RST)
        begin
          con_r <= `USBEP_CON_RST; // [RL9]
          sta_r <= `USBEP_ZERO_RST;
          cnt_r <= 7'h00;
          wp_r <= 6'h00;
          rp_r <= 6'h00;
          bank_r <= 1'b0;
        end
        else
        begin
          if (wr_fire & (ix_r == `USBEP_IX_CON) & sel)
            con_r <= {wd[7:6], con_r[5] & wd[5], con_r[4] & wd[4], con_r[3], wd[2:0]};
          if (nako)
            con_r[`USBEP_CON_NAKO] <= 1'b1; // [RL10]
          if (naki)
            con_r[`USBEP_CON_NAKI] <= 1'b1; // [RL10]
          if (clr)
            con_r[`USBEP_CON_TGL] <= 1'b0;
          else if (done)
            con_r[`USBEP_CON_TGL] <= ~PKT_PID1;
          // Control bits are plain writes, flags clear on zero
          if (wr_fire & (ix_r == `USBEP_IX_STA) & sel)
            sta_r <= {wd[7], sta_r[6] & wd[6], wd[5:4], sta_r[3:0] & wd[3:0]}; // [RL12]
          // Second bank only when the first one is still full
          if (tok & (PKT_KIND == `USBEP_TOK_OUT))
            bank_r <= sta_r[`USBEP_STA_B0] & pp;
          if (stl)
            sta_r[`USBEP_STA_STL] <= 1'b1; // [RL17]
          else if (od & iso)
            sta_r[`USBEP_STA_STL] <= 1'b0; // [RL17]
          if (od & ~bank_r)
            sta_r[`USBEP_STA_B0] <= 1'b1; // [RL13]
          if (od & bank_r)
            sta_r[`USBEP_STA_B1] <= 1'b1; // [RL13]
          if (ind)
          begin
            sta_r[`USBEP_STA_IN_PACKET_READY] <= 1'b0; // [RL16]
            sta_r[`USBEP_STA_IN_COMPLETE_FLAG] <= 1'b1; // [RL19]
          end
          if (su)
            sta_r <= `USBEP_STA_SU_VAL; // [RL18] [RL17]
          if (done)
            cnt_r <= rxcnt_r; // [RL22]
          // SETUP restarts the FIFO even over unread OUT data
          if (clr | (tok & (PKT_KIND == `USBEP_TOK_SETUP))) // [RL14] [RL20]
          begin
            wp_r <= 6'h00;
            rp_r <= 6'h00;
          end
          else
          begin
            if ((RX_VALID & hit) | fw)
              wp_r <= wp_r + 6'd1; // [RL24]
            if ((TX_READ & hit) | fr)
              rp_r <= rp_r + 6'd1; // [RL24]
          end
        end
      end

      assign con_all[8*i +: 8] = con_r;
      assign sta_all[8*i +: 8] = sta_r;
      assign cnt_all[7*i +: 7] = cnt_r;
      assign wp_all[6*i +: 6] = wp_r;
      assign rp_all[6*i +: 6] = rp_r;
      assign hs_all[2*i +: 2] = hs;
    end
  endgenerate

  // Unused fourth slot reads as zero
  assign con_all[31:24] = 8'h00;
  assign sta_all[31:24] = 8'h00;
  assign cnt_all[27:21] = 7'h00;
  assign wp_all[23:18] = 6'h00;
  assign rp_all[23:18] = 6'h00;
  assign hs_all[7:6] = `USBEP_HS_NONE;

  // ==========================================
  // FIFO memory; link side wins each port, bus waits
  wire ram_we = RX_VALID | (wr_fire & dat_ix);
  wire [7:0] ram_wa = RX_VALID ? {PKT_EP, wp_all[6*PKT_EP +: 6]} : {sel_r, wp_all[6*sel_r +: 6]};
  wire [7:0] ram_wd = RX_VALID ? RX_BYTE : wd;
  wire ram_re = TX_READ | (rd_fire & dat_ix);
  wire [7:0] ram_ra = TX_READ ? {PKT_EP, rp_all[6*PKT_EP +: 6]} : {sel_r, rp_all[6*sel_r +: 6]};

  usbep_ram u_ram
  (
    .clk(MCLK),
    .rst(RST),
    .we(ram_we),
    .waddr(ram_wa),
    .wdata(ram_wd),
    .re(ram_re),
    .raddr(ram_ra),
    .rdata(ram_q)
  );
  assign TX_BYTE = ram_q;
  assign TX_AVAIL = wp_all[6*PKT_EP +: 6] != rp_all[6*PKT_EP +: 6];
endmodule

// ==== test/usbep_properties.sv ====
`timescale 1ns/1ns
// ==========================================
// Port checks on the endpoint controller
module usbep_properties
(
  input wire MCLK,
  input wire RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire HREADYOUT,
  input wire LINE_SE0,
  input wire PKT_TOKEN,
  input wire [1:0] PKT_EP,
  input wire HS_VALID,
  input wire [1:0] HS_CODE,
  input wire [6:0] FUNC_ADDR,
  input wire FUNC_ON,
  input wire IRQ
);
  reg [7:0] se0_cnt_r;
  // FIFO data may stretch, so it is left out
  wire take = HSEL && HTRANS[1] && HREADY && HREADYOUT && (HADDR[9:2] != 8'hcf);
  // Saturating run length of SE0
  always @(posedge MCLK)
  begin
    if (RST || !LINE_SE0)
      se0_cnt_r <= 8'h00;
    else if (se0_cnt_r != 8'hff)
      se0_cnt_r <= se0_cnt_r + 8'h01;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  AST_RST_OUT: assert property ($past(RST) |-> !FUNC_ON && FUNC_ADDR == 7'h00 && !IRQ && !HS_VALID)
    else $error("outputs not cleared by reset");
  AST_FON_STICKY: assert property (FUNC_ON |=> FUNC_ON)
    else $error("function enable dropped");
  AST_BUS_RESET: assert property (se0_cnt_r == 8'd40 |-> FUNC_ADDR == 7'h00)
    else $error("address kept through bus reset");
  AST_HS_AFTER_TOKEN: assert property (PKT_TOKEN |=> HS_VALID)
    else $error("no handshake after token");
  AST_HS_ONLY_TOKEN: assert property (!PKT_TOKEN |=> !HS_VALID)
    else $error("handshake without token");
  AST_HS_HOLD: assert property (!HS_VALID |-> $stable(HS_CODE))
    else $error("handshake code moved");
  AST_EP3_REFUSED: assert property (PKT_TOKEN && PKT_EP == 2'h3 |=> HS_CODE == 2'h0)
    else $error("endpoint 3 answered");
  AST_WR_NOWAIT: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  AST_RD_ONEWAIT: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait wrong");
endmodule
bind usbep_top usbep_properties u_props (.*);

// ==== test/usbep_host_model.sv ====
`timescale 1ns/1ns
// ==========================================
// Far-side host: line states, tokens, data
module usbep_host_model
(
  input wire MCLK,
  input wire [7:0] TX_BYTE,
  input wire TX_AVAIL,
  input wire HS_VALID,
  input wire [1:0] HS_CODE,
  output logic LINE_SE0,
  output logic LINE_J,
  output logic PKT_TOKEN,
  output logic [1:0] PKT_KIND,
  output logic [1:0] PKT_EP,
  output logic PKT_DONE,
  output logic PKT_PID1,
  output logic PKT_CRC_ERR,
  output logic PKT_ACKED,
  output logic PKT_SOF,
  output logic [7:0] SOF_FRAME,
  output logic RX_VALID,
  output logic [7:0] RX_BYTE,
  output logic TX_READ
);
  // Quiet, non-idle bus at start
  initial
    {LINE_SE0, LINE_J, PKT_TOKEN, PKT_KIND, PKT_EP, PKT_DONE, PKT_PID1, PKT_CRC_ERR, PKT_ACKED,
     PKT_SOF, SOF_FRAME, RX_VALID, RX_BYTE, TX_READ} = '0;
  // Hold line levels for a number of cycles
  task automatic line(input logic se0, input logic j, input int cyc);
  begin
    LINE_SE0 <= se0;
    LINE_J <= j;
    repeat (cyc) @(posedge MCLK);
  end
  endtask
  task automatic sof(input [7:0] f);
  begin
    PKT_SOF <= 1'b1;
    SOF_FRAME <= f;
    @(posedge MCLK);
    PKT_SOF <= 1'b0;
    @(posedge MCLK);
  end
  endtask
  // Token, then the answer one cycle later
  task automatic token(input [1:0] kind, input [1:0] ep, output [1:0] code);
  begin
    PKT_TOKEN <= 1'b1;
    PKT_KIND <= kind;
    PKT_EP <= ep;
    @(posedge MCLK);
    PKT_TOKEN <= 1'b0;
    @(posedge MCLK);
    code = HS_VALID ? HS_CODE : 2'h0;
  end
  endtask
  // OUT or SETUP: data only after a go-ahead
  task automatic data_out(input [1:0] kind, input [1:0] ep, input int n, input [63:0] d,
                          input logic pid, output [1:0] code);
    int i;
  begin
    token(kind, ep, code);
    if (code == 2'h1)
    begin
      for (i = 0; i < n; i++)
      begin
        RX_VALID <= 1'b1;
        RX_BYTE <= d[8*i +: 8];
        @(posedge MCLK);
      end
      RX_VALID <= 1'b0;
      RX_BYTE <= ~RX_BYTE; // Released byte lane must not look valid
      PKT_DONE <= 1'b1;
      PKT_PID1 <= pid;
      @(posedge MCLK);
      PKT_DONE <= 1'b0;
      @(posedge MCLK);
    end
  end
  endtask
  // IN: pull bytes while any remain, at most 8, then accept
  task automatic data_in(input [1:0] ep, output [1:0] code, output int n, output [63:0] d);
  begin
    token(2'h1, ep, code);
    n = 0;
    d = 64'h0;
    if (code == 2'h1)
    begin
      while (TX_AVAIL === 1'b1 && n < 8)
      begin
        TX_READ <= 1'b1;
        @(posedge MCLK);
        TX_READ <= 1'b0;
        @(posedge MCLK);
        d[8*n +: 8] = TX_BYTE;
        n++;
      end
      PKT_ACKED <= 1'b1;
      @(posedge MCLK);
      PKT_ACKED <= 1'b0;
      @(posedge MCLK);
    end
  end
  endtask
endmodule

// ==== test/usbep_top_test.sv ====
`timescale 1ns/1ns
// ==========================================
// Self-checking bench for the endpoint controller
module usbep_top_test;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  wire [31:0] HRDATA;
  wire HREADYOUT, HRESP, LINE_SE0, LINE_J, PKT_TOKEN, PKT_DONE, PKT_PID1, PKT_CRC_ERR;
  wire PKT_ACKED, PKT_SOF, RX_VALID, TX_READ, TX_AVAIL, HS_VALID, FUNC_ON, IRQ;
  wire [1:0] PKT_KIND, PKT_EP, HS_CODE;
  wire [7:0] SOF_FRAME, RX_BYTE, TX_BYTE;
  wire [6:0] FUNC_ADDR;
  int error_cnt = 0;
  int compares = 0;
  int n, m, i;
  logic [6:0] a;
  logic [7:0] f;
  logic [63:0] d, q;
  logic [1:0] c;
  logic p;
  logic [31:0] rv;
  logic [7:0] ridx [11] = '{8'hbd, 8'hbe, 8'hc2, 8'hc6, 8'hc7, 8'hce, 8'hd4, 8'hd5, 8'he2, 8'hf8, 8'h10};
  logic [7:0] rexp [11] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  usbep_top #(.IDLE_CYC(15'd50)) dut (.*, .HSIZE(3'h2), .HREADY(HREADYOUT));
  usbep_host_model host (.*);
  // ==========================================
  // Checking and bus helpers
  task automatic chk(input [31:0] got, input [31:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic complete_run;
  begin
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Bounded wait for ready at a rising edge
  task automatic wait_rdy;
    int k;
  begin
    k = 0;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        error_cnt++;
        complete_run;
      end
      @(posedge MCLK);
    end
  end
  endtask
  task automatic bus(input logic wr, input [7:0] idx, input [7:0] wd);
  begin
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {22'h0, idx, 2'b00};
    HWRITE <= wr;
    wait_rdy;
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, wd};
    wait_rdy;
    rv = HRDATA;
  end
  endtask
  task automatic wr(input [7:0] idx, input [7:0] v);
    bus(1'b1, idx, v);
  endtask
  task automatic rc(input [7:0] idx, input [31:0] exp);
  begin
    bus(1'b0, idx, 8'h00);
    chk(rv, exp);
  end
  endtask
  // Expected control register: on, NAK irq on, flags, toggle, direction, kind
  function automatic [31:0] con_exp(input logic nak_o, input logic nak_i, input logic tgl,
                                    input logic dir, input [1:0] kind);
    return {24'h0, 2'b11, nak_o, nak_i, tgl, dir, kind};
  endfunction
  initial
    forever #50 MCLK = ~MCLK;
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge MCLK);
    error_cnt++;
    complete_run;
  end
  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(38));
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    wr(8'h10, 8'hff);
    for (i = 0; i < 11; i++)
      rc(ridx[i], {24'h0, rexp[i]});
    // Address, sticky enable, bus reset, end-of-reset
    a = 7'($urandom);
    wr(8'hc6, {1'b1, a});
    rc(8'hc6, {24'h0, 1'b1, a});
    wr(8'hc6, 8'h00);
    @(posedge MCLK);
    chk({FUNC_ON, FUNC_ADDR}, 32'h80);
    wr(8'hc6, {1'b1, a});
    host.line(1'b1, 1'b0, 40);
    host.line(1'b0, 1'b0, 8);
    chk({FUNC_ON, FUNC_ADDR}, 32'h80);
    chk(IRQ, 32'h1);
    rc(8'hbd, 32'h10);
    wr(8'hbd, 8'h00);
    // Frame start, then masked
    f = 8'($urandom);
    wr(8'hbe, 8'h08);
    host.sof(f);
    rc(8'hba, {24'h0, f});
    rc(8'hbd, 32'h08);
    chk(IRQ, 32'h1);
    wr(8'hbe, 8'h00);
    repeat (3) @(posedge MCLK);
    chk(IRQ, 32'h0);
    wr(8'hbd, 8'h00);
    // Idle J into suspend, then resume signalling
    wr(8'hbe, 8'h21);
    host.line(1'b0, 1'b1, 60);
    rc(8'hbd, 32'h01);
    host.line(1'b0, 1'b0, 4);
    rc(8'hbd, 32'h21);
    chk(IRQ, 32'h1);
    wr(8'hbd, 8'h00);
    wr(8'hbe, 8'h00);
    // FIFO resets, then bulk OUT on endpoint 1 until both banks refuse
    wr(8'hd5, 8'h07);
    wr(8'hd5, 8'h00);
    wr(8'hc7, 8'h01);
    wr(8'hd4, 8'hc2);
    wr(8'hc2, 8'h07);
    n = $urandom_range(1, 8);
    d = {$urandom, $urandom};
    p = 1'($urandom);
    host.data_out(2'h0, 2'h1, n, d, p, c);
    chk(c, 32'h1);
    rc(8'hce, 32'h02);
    rc(8'he2, 32'(n));
    for (i = 0; i < n; i++)
      rc(8'hcf, {24'h0, d[8*i +: 8]});
    rc(8'hf8, 32'h02);
    host.data_out(2'h0, 2'h1, 3, d, p, c);
    rc(8'hce, 32'h42);
    rc(8'he2, 32'h3);
    host.data_out(2'h0, 2'h1, 3, d, p, c);
    chk(c, 32'h2);
    rc(8'hd4, con_exp(1'b1, 1'b0, ~p, 1'b0, 2'h2));
    host.data_in(2'h1, c, m, q);
    chk(c, 32'h0);
    // Bulk IN on endpoint 2, then NAK with nothing ready
    wr(8'hc7, 8'h02);
    wr(8'hd4, 8'hc6);
    n = $urandom_range(1, 8);
    d = {$urandom, $urandom};
    for (i = 0; i < n; i++)
      wr(8'hcf, d[8*i +: 8]);
    wr(8'hce, 8'h10);
    host.data_in(2'h2, c, m, q);
    chk(c, 32'h1);
    chk(m, 32'(n));
    for (i = 0; i < n; i++)
      chk(q[8*i +: 8], {24'h0, d[8*i +: 8]});
    rc(8'hce, 32'h01);
    wr(8'hce, 8'h00);
    host.data_in(2'h2, c, m, q);
    chk(c, 32'h2);
    rc(8'hd4, con_exp(1'b0, 1'b1, 1'b0, 1'b1, 2'h2));
    // Stall on endpoint 0, then SETUP wipes status
    wr(8'hf8, 8'h00);
    wr(8'hc7, 8'h00);
    wr(8'hce, 8'ha0);
    host.data_in(2'h0, c, m, q);
    chk(c, 32'h3);
    rc(8'hce, 32'ha8);
    host.data_out(2'h2, 2'h0, 8, d, 1'b0, c);
    chk(c, 32'h1);
    rc(8'hce, 32'h04);
    rc(8'he2, 32'h8);
    rc(8'hf8, 32'h01);
    host.data_out(2'h0, 2'h3, 1, d, 1'b0, c);
    chk(c, 32'h0);
    complete_run;
  end
endmodule
